// File: shared/mau_pkg.sv
// package: constants, register map and state record of the multiply-accumulate unit
package mau_pkg;
	// generation choices, fixed at elaboration
	localparam int MX_W = 16;
	localparam int MY_W = 16;
	localparam int GUARD_W = 4;
	localparam int ADD_IN = 1;
	// format choice: 0 unsigned, 1 two's complement, 2 taken from a control bit
	localparam int X_FMT = 2;
	localparam int Y_FMT = 2;
	localparam int P_W = MX_W + MY_W + GUARD_W;
	localparam int A_W = MX_W + GUARD_W + 4;
	localparam int PH_W = P_W - 32;

	// wishbone register byte addresses
	localparam logic [7:0] ADR_X = 8'h00;
	localparam logic [7:0] ADR_Y = 8'h04;
	localparam logic [7:0] ADR_A = 8'h08;
	localparam logic [7:0] ADR_CTRL = 8'h0C;
	localparam logic [7:0] ADR_PL_LO = 8'h10;
	localparam logic [7:0] ADR_PL_HI = 8'h14;
	localparam logic [7:0] ADR_STROBE = 8'h18;
	localparam logic [7:0] ADR_P_LO = 8'h1C;
	localparam logic [7:0] ADR_P_HI = 8'h20;

	// control register fields
	localparam int CTRL_TCX = 0;
	localparam int CTRL_TCY = 1;
	localparam int CTRL_ACC = 2;
	localparam int CTRL_SUB = 3;
	localparam int CTRL_PRELOAD_CONTROL = 4;
	localparam int CTRL_W = 5;
	// strobe register fields, self clearing
	localparam int STB_XCLK = 0;
	localparam int STB_YCLK = 1;
	localparam int STB_PCLK = 2;

	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef struct packed {
		logic [MX_W-1:0] x_stage;
		logic [MY_W-1:0] y_stage;
		logic [A_W-1:0] a_stage;
		logic [CTRL_W-1:0] ctrl;
		logic [P_W-1:0] pl_stage;
		logic [MX_W-1:0] x_reg;
		logic [MY_W-1:0] y_reg;
		logic [A_W-1:0] a_reg;
		logic tcx;
		logic tcy;
		logic acc;
		logic sub;
		logic [P_W-1:0] p_reg;
		logic ack;
		logic [31:0] dat;
	} mau_state_t;
endpackage

// File: hw/mau_top.sv
// multiply-accumulate unit with a classic wishbone register slave
// Function
// RULE_01 - multiplicand register loads on its clock
// RULE_02 - multiplier register loads on own clock
// RULE_03 - addend loads on either operand clock
// RULE_04 - addend always treated as two's complement
// RULE_05 - addend present only when generated in
// RULE_06 - multiplicand format: unsigned, signed, or pin
// RULE_07 - multiplier format coded the same way
// RULE_08 - multiplicand select pin high means signed
// RULE_09 - multiplier select pin high means signed
// RULE_10 - multiplicand width even, six to thirtytwo
// RULE_11 - multiplier width even, not above multiplicand
// RULE_12 - guard bits two to eight extend product
// RULE_13 - product plus addend, optional accumulate
// RULE_14 - operand formats chosen independently
// RULE_15 - accumulate adds old product register
// RULE_16 - accumulate with subtract removes old product
// RULE_17 - preload loads product register on product clock
// RULE_18 - product bus shows register, product clock only
// RULE_19 - product clock no later than operand clock
// RULE_20 - without preload, product clock stores result
// RULE_21 - no accumulate: product plus addend only
// RULE_22 - extend by format, wrap to register width
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module mau_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [mau_pkg::P_W-1:0] product_o
);

	mau_pkg::mau_state_t st_ff;
	mau_pkg::mau_state_t nxt_st;

	logic wr_go;
	logic xclk;
	logic yclk;
	logic pclk;
	logic opclk;
	logic signed [mau_pkg::P_W-1:0] result;

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
		input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[8*i +: 8] = din[8*i +: 8];
			end
		end
		return m;
	endfunction

	// fixed format, or the control bit when the format is pin selected
	function automatic logic fmt_signed(input int fmt, input logic pin);
		return (fmt == 2) ? pin : (fmt == 1); // RULE_06 RULE_07
	endfunction

	// read data for a register address
	function automatic logic [31:0] rd_mux(input mau_pkg::mau_state_t s, input logic [7:0] adr);
		logic [31:0] d;
		d = mau_pkg::RST_WORD;
		case (adr)
			mau_pkg::ADR_X: d = 32'(s.x_stage);
			mau_pkg::ADR_Y: d = 32'(s.y_stage);
			mau_pkg::ADR_A: d = 32'(s.a_stage);
			mau_pkg::ADR_CTRL: d = 32'(s.ctrl);
			mau_pkg::ADR_PL_LO: d = s.pl_stage[31:0];
			mau_pkg::ADR_PL_HI: d = 32'(s.pl_stage[mau_pkg::P_W-1:32]);
			mau_pkg::ADR_P_LO: d = s.p_reg[31:0];
			mau_pkg::ADR_P_HI: d = 32'(s.p_reg[mau_pkg::P_W-1:32]);
			default: d = mau_pkg::RST_WORD;
		endcase
		return d;
	endfunction

	// a write takes effect at the edge where the master sees ack high
	assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & st_ff.ack;
	assign xclk = wr_go & (wb_adr_i == mau_pkg::ADR_STROBE) & wb_sel_i[0]
		& wb_dat_i[mau_pkg::STB_XCLK];
	assign yclk = wr_go & (wb_adr_i == mau_pkg::ADR_STROBE) & wb_sel_i[0]
		& wb_dat_i[mau_pkg::STB_YCLK];
	assign pclk = wr_go & (wb_adr_i == mau_pkg::ADR_STROBE) & wb_sel_i[0]
		& wb_dat_i[mau_pkg::STB_PCLK];
	// one strobe word may raise several clocks; the product register
	// then takes the result of the operands held before this edge
	assign opclk = xclk | yclk; // RULE_19

	// arithmetic on the captured operands and controls
	always_comb begin
		logic signed [mau_pkg::P_W-1:0] ext_x;
		logic signed [mau_pkg::P_W-1:0] ext_y;
		logic signed [mau_pkg::P_W-1:0] prod;
		logic signed [mau_pkg::P_W-1:0] addend;
		logic signed [mau_pkg::P_W-1:0] sum;
		ext_x = '0;
		ext_y = '0;
		prod = '0;
		addend = '0;
		sum = '0;
		// one extension bit per operand gives mixed signed/unsigned products
		ext_x = mau_pkg::P_W'(signed'({fmt_signed(mau_pkg::X_FMT, st_ff.tcx)
			& st_ff.x_reg[mau_pkg::MX_W-1], st_ff.x_reg})); // RULE_08 RULE_14 RULE_22
		ext_y = mau_pkg::P_W'(signed'({fmt_signed(mau_pkg::Y_FMT, st_ff.tcy)
			& st_ff.y_reg[mau_pkg::MY_W-1], st_ff.y_reg})); // RULE_09 RULE_14 RULE_22
		// the wrapped product is exact modulo the register width
		prod = ext_x * ext_y; // RULE_13 RULE_22
		if (mau_pkg::ADD_IN == 1) begin
			addend = mau_pkg::P_W'(signed'(st_ff.a_reg)); // RULE_04 RULE_05
		end
		sum = prod + addend; // RULE_13 RULE_21
		if (st_ff.acc) begin
			if (st_ff.sub) begin
				sum = sum - signed'(st_ff.p_reg); // RULE_16
			end else begin
				sum = sum + signed'(st_ff.p_reg); // RULE_15
			end
		end
		result = sum;
	end

	always_comb begin
		logic [31:0] w;
		w = '0;
		nxt_st = st_ff;
		// classic handshake: ack for one cycle, then low for at least one
		nxt_st.ack = wb_cyc_i & wb_stb_i & ~st_ff.ack;
		nxt_st.dat = st_ff.dat;
		if (wb_cyc_i & wb_stb_i & ~st_ff.ack) begin
			nxt_st.dat = wb_we_i ? mau_pkg::RST_WORD : rd_mux(st_ff, wb_adr_i);
		end
		if (wr_go) begin
			case (wb_adr_i)
				mau_pkg::ADR_X: begin
					w = merge(32'(st_ff.x_stage), wb_dat_i, wb_sel_i);
					nxt_st.x_stage = w[mau_pkg::MX_W-1:0];
				end
				mau_pkg::ADR_Y: begin
					w = merge(32'(st_ff.y_stage), wb_dat_i, wb_sel_i);
					nxt_st.y_stage = w[mau_pkg::MY_W-1:0];
				end
				mau_pkg::ADR_A: begin
					w = merge(32'(st_ff.a_stage), wb_dat_i, wb_sel_i);
					nxt_st.a_stage = w[mau_pkg::A_W-1:0];
				end
				mau_pkg::ADR_CTRL: begin
					w = merge(32'(st_ff.ctrl), wb_dat_i, wb_sel_i);
					nxt_st.ctrl = w[mau_pkg::CTRL_W-1:0];
				end
				mau_pkg::ADR_PL_LO: begin
					nxt_st.pl_stage[31:0] = merge(st_ff.pl_stage[31:0], wb_dat_i, wb_sel_i);
				end
				mau_pkg::ADR_PL_HI: begin
					w = merge(32'(st_ff.pl_stage[mau_pkg::P_W-1:32]), wb_dat_i, wb_sel_i);
					nxt_st.pl_stage[mau_pkg::P_W-1:32] = w[mau_pkg::PH_W-1:0];
				end
				default: begin
					w = '0;
				end
			endcase
		end
		if (xclk) begin
			nxt_st.x_reg = st_ff.x_stage; // RULE_01
		end
		if (yclk) begin
			nxt_st.y_reg = st_ff.y_stage; // RULE_02
		end
		if (opclk) begin
			if (mau_pkg::ADD_IN == 1) begin
				nxt_st.a_reg = st_ff.a_stage; // RULE_03 RULE_05
			end
			nxt_st.tcx = st_ff.ctrl[mau_pkg::CTRL_TCX];
			nxt_st.tcy = st_ff.ctrl[mau_pkg::CTRL_TCY];
			nxt_st.acc = st_ff.ctrl[mau_pkg::CTRL_ACC]; // RULE_15
			nxt_st.sub = st_ff.ctrl[mau_pkg::CTRL_SUB]; // RULE_16
		end
		if (pclk) begin
			if (st_ff.ctrl[mau_pkg::CTRL_PRELOAD_CONTROL]) begin
				nxt_st.p_reg = st_ff.pl_stage; // RULE_17
			end else begin
				nxt_st.p_reg = result; // RULE_20
			end
		end
		if (rst_i) begin
			nxt_st = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st;
	end

	assign wb_ack_o = st_ff.ack;
	assign wb_dat_o = st_ff.dat;
	assign product_o = st_ff.p_reg; // RULE_18

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_WIDTH_CFG: assert property (mau_pkg::MX_W % 2 == 0 && mau_pkg::MX_W >= 6
		&& mau_pkg::MX_W <= 32 && mau_pkg::MY_W % 2 == 0 && mau_pkg::MY_W >= 6
		&& mau_pkg::MY_W <= mau_pkg::MX_W) // RULE_10 RULE_11
		else $error("operand width out of range");
	AST_GUARD_CFG: assert property (mau_pkg::GUARD_W % 2 == 0 && mau_pkg::GUARD_W >= 2
		&& mau_pkg::GUARD_W <= 8 && mau_pkg::P_W == mau_pkg::MX_W + mau_pkg::MY_W
		+ mau_pkg::GUARD_W) // RULE_12
		else $error("guard width out of range");
	AST_X_LOAD: assert property (xclk |=> st_ff.x_reg == $past(st_ff.x_stage)) // RULE_01
		else $error("multiplicand not captured");
	AST_X_HOLD: assert property (!xclk |=> $stable(st_ff.x_reg)) // RULE_01
		else $error("multiplicand changed without its clock");
	AST_Y_LOAD: assert property (yclk && !xclk |=> st_ff.y_reg == $past(st_ff.y_stage)
		&& $stable(st_ff.x_reg)) // RULE_02
		else $error("multiplier not captured alone");
	AST_A_LOAD: assert property (opclk |=> st_ff.a_reg == $past(st_ff.a_stage)
		&& st_ff.acc == $past(st_ff.ctrl[mau_pkg::CTRL_ACC])) // RULE_03
		else $error("addend or accumulate not captured");
	AST_P_HOLD: assert property (!pclk |=> $stable(product_o)) // RULE_18
		else $error("product changed without its clock");
	AST_PRELOAD: assert property (pclk && st_ff.ctrl[mau_pkg::CTRL_PRELOAD_CONTROL]
		|=> product_o == $past(st_ff.pl_stage)) // RULE_17
		else $error("preload not taken");
	AST_NO_ACC: assert property (pclk && !st_ff.ctrl[mau_pkg::CTRL_PRELOAD_CONTROL] && !st_ff.acc
		|=> product_o == mau_pkg::P_W'($past(result))
		&& $past(result) == mau_pkg::P_W'(signed'($past(st_ff.a_reg)))
		+ mau_pkg::P_W'(signed'({1'b0, $past(st_ff.x_reg)})) * mau_pkg::P_W'(signed'({1'b0,
		$past(st_ff.y_reg)})) || $past(st_ff.tcx) || $past(st_ff.tcy)) // RULE_21
		else $error("unsigned product plus addend wrong");
	AST_SUB: assert property (pclk && !st_ff.ctrl[mau_pkg::CTRL_PRELOAD_CONTROL] && st_ff.acc
		&& st_ff.sub && st_ff.a_reg == '0 && (st_ff.x_reg == '0 || st_ff.y_reg == '0)
		|=> product_o == mau_pkg::P_W'(-$past(st_ff.p_reg))) // RULE_16
		else $error("subtract of old product wrong");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

// File: testbench/mau_wbm.sv
// classic wishbone master standing in for the surrounding datapath logic
`timescale 1ns/1ns
`default_nettype none
module mau_wbm (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [31:0] dat_o
);
	initial begin
		{cyc_o, stb_o, we_o, adr_o, dat_o} = '0;
	end
	// request held until the edge that samples ack, then released for a cycle
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'b11, we, adr, wd};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 64);
		rd = dat_i;
		{cyc_o, stb_o} <= 2'b00;
		// released data shows the inverse so stale values cannot pass
		dat_o <= ~wd;
	endtask
endmodule
`default_nettype wire

// File: testbench/mau_top_tb.sv
// self-checking bench for the multiply-accumulate unit
`timescale 1ns/1ns
`default_nettype none
module mau_top_tb;
	typedef logic [mau_pkg::P_W-1:0] mau_p_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack;
	logic [7:0] adr;
	logic [31:0] wdat, rdat;
	mau_p_t prod, pm, pl;
	logic [15:0] xl, yl;
	logic [23:0] al;
	logic [4:0] cl;
	int failures = 0;
	int comparisons = 0;
	always #20 clk_i = ~clk_i;
	mau_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.product_o(prod));
	mau_wbm wbm (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .dat_o(wdat));
	task automatic check(input string what, input mau_p_t exp, input mau_p_t got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wbm.xfer(1'b1, a, d, r);
	endtask
	task automatic rd_p(output mau_p_t p);
		logic [31:0] lo, hi;
		wbm.xfer(1'b0, mau_pkg::ADR_P_LO, 32'h0, lo);
		wbm.xfer(1'b0, mau_pkg::ADR_P_HI, 32'h0, hi);
		p = {hi[mau_pkg::PH_W-1:0], lo};
	endtask
	// reference: extend by format, addend always signed, wrap to register width
	function automatic mau_p_t mac(logic [15:0] x, logic [15:0] y, logic [23:0] a,
		logic [4:0] c, mau_p_t p);
		mau_p_t ex, ey, r;
		ex = c[0] ? mau_p_t'($signed(x)) : mau_p_t'(x);
		ey = c[1] ? mau_p_t'($signed(y)) : mau_p_t'(y);
		r = ex * ey + mau_p_t'($signed(a));
		if (c[2]) r = c[3] ? r - p : r + p;
		return r;
	endfunction
	task automatic op(input logic [15:0] x, input logic [15:0] y, input logic [23:0] a,
		input logic [4:0] c);
		mau_p_t got;
		{xl, yl, al, cl} = {x, y, a, c};
		wr(mau_pkg::ADR_X, 32'(x));
		wr(mau_pkg::ADR_Y, 32'(y));
		wr(mau_pkg::ADR_A, 32'(a));
		wr(mau_pkg::ADR_CTRL, 32'(c));
		wr(mau_pkg::ADR_STROBE, 32'h0000_0003);
		wr(mau_pkg::ADR_STROBE, 32'h0000_0004);
		pm = c[4] ? pl : mac(x, y, a, c, pm);
		rd_p(got);
		check("product", pm, got);
		check("product_o", pm, prod);
	endtask
	task automatic t_reset;
		mau_p_t got;
		logic [31:0] r;
		rd_p(got);
		check("reset product", '0, got);
		wbm.xfer(1'b0, 8'hFC, 32'h0, r);
		check("unmapped read", '0, mau_p_t'(r));
		pm = '0;
		$display("test reset done");
	endtask
	task automatic t_formats;
		for (int i = 0; i < 4; i++) begin
			op(16'hFFFE, 16'h8003, 24'hFFFFF0, 5'(i));
		end
		op(16'hFFFF, 16'hFFFF, 24'h7FFFFF, 5'h00);
		$display("test formats done");
	endtask
	task automatic t_acc;
		op(16'h1234, 16'h00F0, 24'h000010, 5'h07);
		op(16'h0003, 16'hFFFD, 24'hFFFFFF, 5'h0E);
		op(16'h8000, 16'h7FFF, 24'h000001, 5'h0F);
		op(16'h0000, 16'h1234, 24'h000000, 5'h0C);
		$display("test accumulate done");
	endtask
	task automatic t_preload;
		pl = 36'h9_8765_4321;
		wr(mau_pkg::ADR_PL_LO, pl[31:0]);
		wr(mau_pkg::ADR_PL_HI, 32'(pl[35:32]));
		op(16'h0101, 16'h0202, 24'h0, 5'h17);
		op(16'h0101, 16'h0202, 24'h0, 5'h04);
		$display("test preload done");
	endtask
	task automatic t_clocks;
		mau_p_t got;
		wr(mau_pkg::ADR_X, 32'h0000_0077);
		wr(mau_pkg::ADR_STROBE, 32'h0000_0001);
		rd_p(got);
		check("held product", pm, got);
		wr(mau_pkg::ADR_STROBE, 32'h0000_0004);
		pm = mac(16'h0077, yl, al, cl, pm);
		rd_p(got);
		check("new multiplicand only", pm, got);
		wr(mau_pkg::ADR_Y, 32'h0000_0055);
		wr(mau_pkg::ADR_STROBE, 32'h0000_0002);
		rd_p(got);
		check("held product after y", pm, got);
		wr(mau_pkg::ADR_STROBE, 32'h0000_0004);
		pm = mac(16'h0077, 16'h0055, al, cl, pm);
		rd_p(got);
		check("new multiplier only", pm, got);
		$display("test clocks done");
	endtask
	task automatic stop_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		pl = '0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_formats;
		t_acc;
		t_preload;
		t_clocks;
		stop_test;
	end
	// about 107 bus cycles are needed; the limit leaves wide margin
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		stop_test;
	end
endmodule
`default_nettype wire
